// [bench/host_terminal_model.sv]
// host terminal model: paced 8n1 characters plus the decoded-character strobe
module host_terminal_model (
  input  wire logic       clk,
  input  wire logic [7:0] bit_cycles,
  output logic            line,
  output logic            valid,
  output logic [7:0]      data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // line state
  // ----------------------------------------------------------
  // idle high, as a pulled-up serial line
  initial begin
    line  = 1'b1;
    valid = 1'b0;
    data  = 8'h00;
  end
  // ----------------------------------------------------------
  // transfers
  // ----------------------------------------------------------
  // one frame, lsb first; strobe only after the stop bit has gone out
  task automatic send_char(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= frame[i];
      repeat (bit_cycles) @(posedge clk);
    end
    valid <= 1'b1;
    data  <= c;
    @(posedge clk);
    valid <= 1'b0;
    data  <= ~c;  // stale byte must not look valid
  endtask : send_char
  // silent line for whole characters; callers use it between escapes and commands
  task automatic idle(input int chars);
    repeat (chars * 10 * bit_cycles) @(posedge clk);
  endtask : idle
endmodule : host_terminal_model

// [bench/serial_pause_command_framer_bench.sv]
// self-checking bench of the serial pause command framer
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module serial_pause_command_framer_bench;
  import pause_framer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        l1, l2, v1, v2, tx_buffer_empty = 1'b0;
  logic [7:0]  d1, d2;
  logic        radio_tx_stop, radio_suspend, address_start, cmd_ready, cmd_port;
  logic [31:0] q;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  logic [7:0]  r;
  logic [7:0]  bcyc = 8'h04;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // ----------------------------------------------------------
  // design and two host terminals
  // ----------------------------------------------------------
  serial_pause_command_framer #(.CMD_MAX(16), .PAUSE_CAP_CYC(2000)) DUT (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_to_module_line(l1),
    .second_port_host_to_module_line(l2), .rx_valid({v2, v1}), .rx_data({d2, d1}),
    .tx_buffer_empty(tx_buffer_empty), .radio_tx_stop(radio_tx_stop),
    .radio_suspend(radio_suspend), .address_start(address_start),
    .cmd_ready(cmd_ready), .cmd_port(cmd_port));
  // 4 cycles a bit keeps a character at 40 cycles
  host_terminal_model hm1 (.clk(clk), .bit_cycles(bcyc), .line(l1), .valid(v1), .data(d1));
  host_terminal_model hm2 (.clk(clk), .bit_cycles(bcyc), .line(l2), .valid(v2), .data(d2));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) begin
      err_total++;
      finish_test();
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  // bounded wait for an output pulse; n is -1 when none came
  task automatic wait_ev(input int sel, input int lim);
    n = 0;
    while (n < lim) begin
      @(posedge clk);
      if ((sel == 0 ? cmd_ready : sel == 1 ? radio_tx_stop : address_start) === 1'b1)
        return;
      n++;
    end
    n = -1;
  endtask : wait_ev
  // leading pause, the string, then the closing pause while watching for a framed command
  task automatic frame(input int p, input string s);
    hm1.idle(4);
    for (int i = 0; i < s.len(); i++) begin
      if (p == 0) hm1.send_char(s[i]);
      else hm2.send_char(s[i]);
    end
    wait_ev(0, 300);  // bounded like a host reply timeout
  endtask : frame
  // three escape characters, each fenced by pauses
  task automatic escape(input logic [7:0] c);
    repeat (3) begin
      hm1.idle(4);
      hm1.send_char(c);
    end
    hm1.idle(4);
  endtask : escape
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0]  ofs[4];
    logic [31:0] rv[4];
    ofs = '{CTRL_OFS, PAUSE_OFS, BITTIME_OFS, 8'h20};
    rv  = '{32'h3, 32'h3, 32'h104, 32'h0};
    void'($urandom(3143));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped place
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      `CHK(q, rv[i])
    end
    bus(1'b1, BITTIME_OFS, 32'h4);
    bus(1'b1, PAUSE_OFS, 32'h1);
    bus(1'b0, PAUSE_OFS, 32'h0);
    `CHK(q, 32'h3)
    $display("test 1 done");
    // cr lf terminated command, reply flag set then cleared
    frame(0, "AB\r\n");
    `CHK(n >= 0, 1'b1)
    `CHK(cmd_port, 1'b0)
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[2], 1'b1)
    bus(1'b1, REPLY_OFS, 32'h1);  // reply seen before the next command
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[2], 1'b0)
    bus(1'b0, CMD_OFS, 32'h0);
    `CHK(q, 32'h42)
    // a char after the cr is extra: framed, answered with an error
    frame(0, "AB\rX");
    `CHK(n >= 0, 1'b1)
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[5:2], 4'h5)
    bus(1'b1, REPLY_OFS, 32'h1);
    $display("test 2 done");
    // commands off: treated as data; address start needs a pause first
    bus(1'b1, CTRL_OFS, 32'h2);
    frame(0, "AB");
    `CHK(n, -1)
    hm1.idle(4);
    r = 8'($urandom % 256);
    hm1.send_char(r);
    wait_ev(2, 40);
    `CHK(n >= 0, 1'b1)
    hm1.send_char(~r);
    wait_ev(2, 20);
    `CHK(n, -1)
    $display("test 3 done");
    // escapes work with commands off
    escape(CHAR_PLUS);
    `CHK(radio_suspend, 1'b1)
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[1], 1'b1)
    frame(0, "AB");
    `CHK(n >= 0, 1'b1)
    escape(CHAR_MINUS);
    `CHK(radio_suspend, 1'b0)
    frame(0, "AB");
    `CHK(n, -1)
    $display("test 4 done");
    // second port off, then diagnostics
    bus(1'b1, CTRL_OFS, 32'h3);
    frame(1, "AB");
    `CHK(n, -1)
    bus(1'b1, CTRL_OFS, 32'h7);
    frame(1, "AB");
    `CHK(n >= 0, 1'b1)
    `CHK(cmd_port, 1'b1)
    $display("test 5 done");
    // end of transmission after 3 chars of silence, capped at 2000 cycles
    tx_buffer_empty <= 1'b1;
    hm1.send_char(8'h00);
    wait_ev(1, 400);
    `CHK(n >= 110 && n <= 125, 1'b1)
    tx_buffer_empty <= 1'b0;
    hm1.send_char(8'h00);
    wait_ev(1, 300);
    `CHK(n, -1)
    bus(1'b1, PAUSE_OFS, 32'hFF);
    bus(1'b0, PAUSE_OFS, 32'h0);
    `CHK(q, 32'hFF)
    tx_buffer_empty <= 1'b1;
    hm1.send_char(8'h00);
    wait_ev(1, 2500);
    `CHK(n >= 1985 && n <= 2010, 1'b1)
    $display("test 6 done");
    finish_test();
  end
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : serial_pause_command_framer_bench

// [verilog/pause_framer_pkg.sv]
// constants shared by the serial pause command framer
package pause_framer_pkg;
  // ------------------------------------------------------------
  // register map (Avalon-MM word addresses in bytes)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] PAUSE_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] CMD_OFS     = 8'h0C;
  localparam logic [7:0] REPLY_OFS   = 8'h10;
  localparam logic [7:0] BITTIME_OFS = 8'h14;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CMD_EN_BIT   = 0;
  localparam int CRLF_EN_BIT  = 1;
  localparam int PORT2_BIT    = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h3;
  localparam logic [7:0]  PAUSE_RESET     = 8'h03;
  localparam logic [7:0]  PAUSE_MIN       = 8'h03;
  localparam logic [15:0] BITTIME_RESET   = 16'h0104;
  localparam logic [3:0]  BITS_PER_CHAR   = 4'hA;
  localparam logic [7:0]  CHAR_CR         = 8'h0D;
  localparam logic [7:0]  CHAR_LF         = 8'h0A;
  localparam logic [7:0]  CHAR_PLUS       = 8'h2B;
  localparam logic [7:0]  CHAR_MINUS      = 8'h2D;
  localparam logic [1:0]  ESC_COUNT       = 2'h3;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ       = 40000000;
  localparam int PAUSE_CAP_MS = 170;
  localparam int PAUSE_CAP_CYCLES = PAUSE_CAP_MS * (CLK_HZ / 1000);
endpackage : pause_framer_pkg

// [verilog/serial_pause_command_framer.sv]
// serial pause detector, command framer and escape handler, two ports
// ------------------------------------------------------------
// module
// ------------------------------------------------------------
// Overview of operation
// R1: commands interpreted only while enable on
// R2: command framed by pauses both sides
// R3: extra chars rejected, CR or CRLF ok
// R4: host waits for reply before next command
// R5: host applies reply timeout
// R6: every command gets ok or error reply
// R7: reply goes out on arrival port
// R8: second port role off or diagnostics
// R9: CRLF appended to replies, switchable
// R10: command enable defaults on, writable
// R11: three pluses with pauses enter command mode
// R12: entry sequence works regardless of enable
// R13: command mode forces enable, radio suspended
// R14: three minuses leave mode, restore enable
// R15: host avoids escapes during data traffic
// R16: pause means no line transitions
// R17: buffer empty plus pause ends transmission
// R18: command valid only after leading pause
// R19: address start char needs leading pause
// R20: pause length 3 to 255 chars
// R21: pause time is length times char time
// R22: pause capped at 170 ms
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
module serial_pause_command_framer
  import pause_framer_pkg::*;
#(
  parameter int CMD_MAX        = 16,
  parameter int PAUSE_CAP_CYC  = PAUSE_CAP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        host_to_module_line,
  input  wire logic        second_port_host_to_module_line,
  input  wire logic [1:0]  rx_valid,
  input  wire logic [15:0] rx_data,
  input  wire logic        tx_buffer_empty,
  output logic             radio_tx_stop,
  output logic             radio_suspend,
  output logic             address_start,
  output logic             cmd_ready,
  output logic             cmd_port
);
  // rx_valid[p] / rx_data[8p+:8]: decoded characters per port from the uart
  localparam int CW = $clog2(CMD_MAX + 1);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [7:0]  pause_len_q;
  logic [15:0] bit_time_q;
  logic        cmd_mode_q;
  logic [1:0]  reply_pend_q;
  logic [1:0]  reply_err_q;
  logic [CMD_MAX*8-1:0] cmd_buf_q [2];
  logic [CW-1:0] cmd_len_q [2];
  logic [1:0]  cmd_ok_q;
  logic [1:0]  cmd_run_q;
  logic [1:0]  ack_q;
  logic [1:0]  sync1_q;
  logic [1:0]  sync2_q;
  logic [1:0]  line_prev_q;
  logic [1:0]  port_on;
  logic [1:0]  pause_now;
  logic [1:0]  pause_seen_q;
  logic [1:0]  esc_plus_n;
  logic [1:0]  esc_minus_n;
  logic        cmds_live;
  logic [31:0] pause_cycles;
  logic [31:0] char_cycles;
  logic        pause_prev0_q;

  // sampled line levels, two flip-flops ahead of any reader
  always_ff @(posedge clk) begin
    sync1_q <= {second_port_host_to_module_line, host_to_module_line};
    sync2_q <= sync1_q;
    line_prev_q <= sync2_q;
  end

  // effective pause: chars * bits * bit time, capped
  assign char_cycles  = 32'(bit_time_q) * 32'(BITS_PER_CHAR);                // see R21
  assign pause_cycles = (32'(pause_len_q) * char_cycles > 32'(PAUSE_CAP_CYC)) ?
                        32'(PAUSE_CAP_CYC) : 32'(pause_len_q) * char_cycles; // see R22
  // command mode overrides the user enable without touching it
  assign cmds_live = ctrl_q[CMD_EN_BIT] | cmd_mode_q;                       // see R13
  assign port_on   = {ctrl_q[PORT2_BIT], 1'b1};                             // see R8

  // ------------------------------------------------------------
  // per-port pause detection and framing
  // ------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [31:0]  idle_q;
      logic [1:0]   plus_q;
      logic [1:0]   minus_q;
      logic         esc_ok_q;
      logic         edge_w;
      logic [7:0]   ch;
      logic         chr;
      logic         idle_done;
      logic         cr_seen_q;
      logic         lf_seen_q;
      assign edge_w = sync2_q[p] ^ line_prev_q[p];
      assign ch     = rx_data[8*p +: 8];
      assign chr    = rx_valid[p] & port_on[p];
      // pause counts only time without any transition on the line
      assign idle_done = (idle_q >= pause_cycles);                          // see R16
      assign pause_now[p] = idle_done;
      always_ff @(posedge clk) begin
        if (reset) begin
          idle_q <= 32'h0000_0000;
        end else if (edge_w) begin
          idle_q <= 32'h0000_0000;                                          // see R16
        end else if (!idle_done) begin
          idle_q <= idle_q + 32'h0000_0001;
        end
      end
      // pause_seen: a pause happened before the current char run
      always_ff @(posedge clk) begin
        if (reset) begin
          pause_seen_q[p] <= 1'b1;
        end else if (idle_done) begin
          pause_seen_q[p] <= 1'b1;
        end else if (chr) begin
          pause_seen_q[p] <= 1'b0;
        end
      end
      // escape counting: each char must be a lone char between pauses
      always_ff @(posedge clk) begin
        if (reset) begin
          plus_q   <= 2'h0;
          minus_q  <= 2'h0;
          esc_ok_q <= 1'b0;
        end else if (chr) begin
          esc_ok_q <= pause_seen_q[p] & (ch == CHAR_PLUS || ch == CHAR_MINUS);
          if (!pause_seen_q[p]) begin
            plus_q  <= 2'h0;
            minus_q <= 2'h0;
          end
          if (!esc_ok_q && !pause_seen_q[p]) begin
            esc_ok_q <= 1'b0;
          end
        end else if (idle_done && esc_ok_q) begin
          esc_ok_q <= 1'b0;
          if (cmd_buf_q[p][7:0] == CHAR_PLUS && cmd_len_q[p] == CW'(1)) begin
            plus_q  <= (plus_q == ESC_COUNT) ? 2'h0 : plus_q + 2'h1;        // see R11
            minus_q <= 2'h0;
          end else if (cmd_buf_q[p][7:0] == CHAR_MINUS && cmd_len_q[p] == CW'(1)) begin
            minus_q <= (minus_q == ESC_COUNT) ? 2'h0 : minus_q + 2'h1;      // see R14
            plus_q  <= 2'h0;
          end
        end else if (esc_plus_n[p] | esc_minus_n[p]) begin
          plus_q  <= 2'h0;
          minus_q <= 2'h0;
        end
      end
      assign esc_plus_n[p]  = (plus_q == ESC_COUNT);                        // see R12
      assign esc_minus_n[p] = (minus_q == ESC_COUNT);
      // command buffer: chars collected only in a run that began after a pause
      // a cr, and an lf right after it, close a command and are not stored, so the last char stays readable
      always_ff @(posedge clk) begin
        if (reset) begin
          cmd_buf_q[p] <= '0;
          cmd_len_q[p] <= '0;
          cmd_ok_q[p]  <= 1'b0;
          cmd_run_q[p] <= 1'b0;
          cr_seen_q    <= 1'b0;
          lf_seen_q    <= 1'b0;
        end else if (chr) begin
          if (pause_seen_q[p]) begin
            cmd_buf_q[p] <= {{(CMD_MAX*8-8){1'b0}}, ch};
            cmd_len_q[p] <= CW'(1);
            cmd_ok_q[p]  <= 1'b1;                                           // see R18
            cmd_run_q[p] <= 1'b1;
            cr_seen_q    <= 1'b0;
            lf_seen_q    <= 1'b0;
          end else if (cr_seen_q) begin
            // after the cr only a single lf may follow; anything else spoils the run
            cmd_ok_q[p] <= cmd_ok_q[p] & (ch == CHAR_LF) & ~lf_seen_q;     // see R3
            lf_seen_q   <= 1'b1;
          end else if (ch == CHAR_CR) begin
            cr_seen_q <= 1'b1;                                              // see R3
          end else if (cmd_len_q[p] < CW'(CMD_MAX)) begin
            cmd_buf_q[p] <= {cmd_buf_q[p][CMD_MAX*8-9:0], ch};
            cmd_len_q[p] <= cmd_len_q[p] + CW'(1);
          end else begin
            cmd_ok_q[p] <= 1'b0;                                            // overflow
          end
        end else if (idle_done) begin
          cmd_ok_q[p]  <= 1'b0;
          cmd_run_q[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // closing pause on any run, valid or spoiled, frames a command; escapes are separate
  logic [1:0] frame_end;
  logic [1:0] is_escape;
  generate
    for (p = 0; p < 2; p++) begin : g_frame
      assign is_escape[p] = (cmd_len_q[p] == CW'(1)) &&
                            (cmd_buf_q[p][7:0] == CHAR_PLUS || cmd_buf_q[p][7:0] == CHAR_MINUS);
      // framed by pauses on both sides and enabled
      // a spoiled run still frames, so that it is answered with an error
      assign frame_end[p] = pause_now[p] & cmd_run_q[p] & ~is_escape[p] &
                            cmds_live & (p == 0 ? 1'b1 : ctrl_q[PORT2_BIT]); // see R1 R2 R7
    end
  endgenerate

  // command mode state and radio suspension
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_mode_q <= 1'b0;
    end else if (|esc_plus_n) begin
      cmd_mode_q <= 1'b1;                                                   // see R11
    end else if (|esc_minus_n) begin
      cmd_mode_q <= 1'b0;                                                   // see R14
    end
  end

  // replies: one pending per port, host clears via reply register
  logic [1:0] reply_set;
  assign reply_set = frame_end | esc_plus_n | esc_minus_n;                  // see R6
  always_ff @(posedge clk) begin
    if (reset) begin
      reply_pend_q <= 2'h0;
      reply_err_q  <= 2'h0;
    end else begin
      // set wins over clear so no reply is lost
      reply_pend_q <= (reply_pend_q & ~ack_q) | reply_set;
      reply_err_q  <= (reply_err_q & ~(ack_q & ~reply_set)) |
                      (frame_end & ~cmd_ok_q);
    end
  end

  // radio control and address start pulse
  logic addr_d;
  assign addr_d = rx_valid[0] & pause_seen_q[0] & ~cmds_live;               // see R19
  always_ff @(posedge clk) begin
    if (reset) begin
      radio_tx_stop <= 1'b0;
      radio_suspend <= 1'b0;
      address_start <= 1'b0;
      cmd_ready     <= 1'b0;
      cmd_port      <= 1'b0;
      pause_prev0_q <= 1'b1;
    end else begin
      pause_prev0_q <= pause_now[0];
      radio_tx_stop <= tx_buffer_empty & pause_now[0] & ~pause_prev0_q;     // see R17
      radio_suspend <= cmd_mode_q;                                          // see R13
      address_start <= addr_d;
      cmd_ready     <= |frame_end;
      // port of the last command stands until the next one, the cmd read relies on it
      if (|frame_end) begin
        cmd_port <= frame_end[1] & ~frame_end[0];                           // see R7
      end
    end
  end

  // ------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ------------------------------------------------------------
  logic        acc;
  logic        wr_hit;
  logic [31:0] rd_mux;
  logic [7:0]  len_w;
  assign acc    = (avs_read | avs_write) & avs_waitrequest;
  assign wr_hit = avs_write & ~avs_waitrequest;
  assign len_w  = (avs_writedata[7:0] < PAUSE_MIN) ? PAUSE_MIN : avs_writedata[7:0];
  assign rd_mux =
    (avs_address == CTRL_OFS)    ? {29'h0, ctrl_q} :
    (avs_address == PAUSE_OFS)   ? {24'h0, pause_len_q} :
    (avs_address == STATUS_OFS)  ? {26'h0, reply_err_q, reply_pend_q, cmd_mode_q,
                                     pause_now[0]} :
    (avs_address == CMD_OFS)     ? {24'h0, cmd_buf_q[cmd_port][7:0]} :
    (avs_address == BITTIME_OFS) ? {16'h0, bit_time_q} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~acc;
      avs_readdata    <= acc ? rd_mux : avs_readdata;
    end
  end
  // register writes take effect at the accepting edge
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q      <= CTRL_RESET;                                            // see R10
      pause_len_q <= PAUSE_RESET;                                           // see R20
      bit_time_q  <= BITTIME_RESET;
      ack_q       <= 2'h0;
    end else begin
      ack_q <= (wr_hit && avs_address == REPLY_OFS) ? avs_writedata[1:0] : 2'h0;
      if (wr_hit && avs_address == CTRL_OFS) begin
        ctrl_q <= avs_writedata[2:0];                                       // see R9 R10
      end
      if (wr_hit && avs_address == PAUSE_OFS) begin
        pause_len_q <= len_w;                                               // see R20
      end
      if (wr_hit && avs_address == BITTIME_OFS) begin
        bit_time_q <= avs_writedata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_pause_floor: assert property (@(posedge clk) disable iff (reset)
    pause_len_q >= PAUSE_MIN) else $error("pause length below minimum"); // see R20
  a_pause_cap: assert property (@(posedge clk) disable iff (reset)
    pause_cycles <= 32'(PAUSE_CAP_CYC)) else $error("pause above cap"); // see R22
  a_mode_enables: assert property (@(posedge clk) disable iff (reset)
    cmd_mode_q |-> cmds_live) else $error("mode without enable"); // see R13
  a_suspend_follow: assert property (@(posedge clk) disable iff (reset)
    cmd_mode_q |=> radio_suspend) else $error("radio not suspended"); // see R13
  a_frame_enabled: assert property (@(posedge clk) disable iff (reset)
    frame_end[0] |-> cmds_live && pause_now[0]) else $error("bad frame"); // see R1
  a_reply_set: assert property (@(posedge clk) disable iff (reset)
    frame_end[0] |=> reply_pend_q[0]) else $error("reply lost"); // see R6
  a_edge_clears: assert property (@(posedge clk) disable iff (reset)
    (sync2_q[0] != line_prev_q[0]) |=> g_port[0].idle_q == 32'h0) else $error("edge kept"); // see R16
  a_enter_mode: assert property (@(posedge clk) disable iff (reset)
    esc_plus_n[0] |=> cmd_mode_q) else $error("entry missed"); // see R11
  a_tx_stop: assert property (@(posedge clk) disable iff (reset)
    radio_tx_stop |-> $past(tx_buffer_empty)) else $error("stop with data"); // see R17
  // framing, port, mode, reply and bus handshake checks
  // each one except the two avalon wait checks names the rule whose breach it would catch
  a_port_hold: assert property (@(posedge clk) disable iff (reset)
    !(|frame_end) |=> $stable(cmd_port)) else $error("port moved"); // see R7
  a_port_two: assert property (@(posedge clk) disable iff (reset)
    (frame_end == 2'b10) |=> cmd_port) else $error("wrong port"); // see R7
  a_port_off: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q[PORT2_BIT] |-> !frame_end[1]) else $error("port off framed"); // see R8
  a_frame_port1: assert property (@(posedge clk) disable iff (reset)
    frame_end[1] |-> cmds_live && pause_now[1]) else $error("bad frame two"); // see R1
  a_ready_pulse: assert property (@(posedge clk) disable iff (reset)
    (|frame_end) |=> cmd_ready) else $error("ready missed"); // see R2
  a_no_cmd_off: assert property (@(posedge clk) disable iff (reset)
    !cmds_live |-> frame_end == 2'b00) else $error("framed while off"); // see R1
  a_err_with_pend: assert property (@(posedge clk) disable iff (reset)
    $rose(reply_err_q[0]) |-> reply_pend_q[0]) else $error("error without reply"); // see R6
  a_leave_mode: assert property (@(posedge clk) disable iff (reset)
    (|esc_minus_n) && !(|esc_plus_n) |=> !cmd_mode_q) else $error("exit missed"); // see R14
  a_enable_kept: assert property (@(posedge clk) disable iff (reset)
    !wr_hit |=> $stable(ctrl_q)) else $error("enable touched"); // see R14
  a_suspend_drop: assert property (@(posedge clk) disable iff (reset)
    !cmd_mode_q |=> !radio_suspend) else $error("radio kept suspended"); // see R14
  a_pause_mark: assert property (@(posedge clk) disable iff (reset)
    pause_now[0] |=> pause_seen_q[0]) else $error("pause not marked"); // see R18
  a_run_start: assert property (@(posedge clk) disable iff (reset)
    $rose(cmd_run_q[0]) |-> $past(pause_seen_q[0])) else $error("run without pause"); // see R18
  a_addr_pause: assert property (@(posedge clk) disable iff (reset)
    address_start |-> $past(pause_seen_q[0])) else $error("address without pause"); // see R19
  a_stop_pause: assert property (@(posedge clk) disable iff (reset)
    radio_tx_stop |-> $past(pause_now[0])) else $error("stop without pause"); // see R17
  a_wait_one: assert property (@(posedge clk) disable iff (reset)
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
  a_wait_answer: assert property (@(posedge clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_ack_clears: assert property (@(posedge clk) disable iff (reset)
    ack_q[0] && !reply_set[0] |=> !reply_pend_q[0]) else $error("reply not cleared"); // see R6
endmodule : serial_pause_command_framer
